// ---- hw/urx_pkg.sv ----
// shared constants and types for the serial receive block
package urx_pkg;

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	localparam int         ADDR_W      = 2;
	localparam int         DATA_W      = 8;
	localparam logic [1:0] ADDR_CTRL   = 2'h0;
	localparam logic [1:0] ADDR_STATUS = 2'h1;
	localparam logic [1:0] ADDR_DATA   = 2'h2;

	// ----------------------------------------------------------------
	// serial_ctrl_one fields and reset value
	// ----------------------------------------------------------------
	localparam int         CB_PORT_EN   = 0;
	localparam int         CB_RX_EN     = 1;
	localparam int         CB_NINE_SEL  = 2;
	localparam int         CB_PAR_EN    = 3;
	localparam int         CB_PAR_ODD   = 4;
	localparam int         CB_TWO_STOP  = 5;
	localparam int         CB_IRQ_EN    = 6;
	localparam logic [7:0] CTRL_MASK    = 8'h7f;
	localparam logic [7:0] CTRL_RESET   = 8'h00;

	// ----------------------------------------------------------------
	// serial_status_reg fields
	// ----------------------------------------------------------------
	localparam int SB_AVAIL   = 0;
	localparam int SB_OVERRUN = 1;
	localparam int SB_NOISE   = 2;
	localparam int SB_FRAMING_ERR_FLAG    = 3;
	localparam int SB_PARITY_ERR_FLAG    = 4;
	localparam int SB_IDLE    = 5;
	localparam int SB_NINTH   = 6;

	// ----------------------------------------------------------------
	// framing, oversampling and buffer
	// ----------------------------------------------------------------
	localparam int         WORD_W         = 9;
	localparam int         ENTRY_W        = 11;
	localparam int         EB_FRAMING_ERR_FLAG        = 9;
	localparam int         EB_PARITY_ERR_FLAG        = 10;
	localparam logic [3:0] LAST_IDX_EIGHT = 4'h7;
	localparam logic [3:0] LAST_IDX_NINE  = 4'h8;
	localparam int         OVERSAMPLE_DEF = 16;
	localparam int         FIFO_DEPTH_DEF = 2;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_START   = 3'b001,
		ST_DATA    = 3'b010,
		ST_STOP1   = 3'b011,
		ST_STOP2   = 3'b100,
		ST_BRKWAIT = 3'b101
	} urx_state_t;

endpackage

// ---- hw/urx_bit_sampler.sv ----
// mid-bit three-sample majority voter running on the oversampling tick
`timescale 1ns/1ps
module urx_bit_sampler #(
	parameter int OVERSAMPLE = urx_pkg::OVERSAMPLE_DEF
) (
	input  wire logic mclk,
	input  wire logic reset,
	input  wire logic tick,
	input  wire logic restart,
	input  wire logic rxIn,
	output logic      bitDone,
	output logic      bitLevel,
	output logic      bitNoise
);
	import urx_pkg::*;

	localparam int         PH_W  = $clog2(OVERSAMPLE);
	localparam logic [PH_W-1:0] PH_LAST = PH_W'(OVERSAMPLE - 1);
	localparam logic [PH_W-1:0] PH_MID  = PH_W'(OVERSAMPLE / 2);

	if (OVERSAMPLE < 8 || (OVERSAMPLE & (OVERSAMPLE - 1)) != 0) begin : g_chk
		$error("OVERSAMPLE must be a power of two of at least 8");
	end

	logic [PH_W-1:0] phase_r, phase_nxt;
	logic [2:0]      samp_r, samp_nxt;
	logic            done_r, done_nxt;
	logic            level_r, level_nxt;
	logic            noise_r, noise_nxt;

	// ----------------------------------------------------------------
	// phase count and sampling
	// ----------------------------------------------------------------
	// phase 0 is the first tick after the one that saw the falling edge, so the vote lands mid-bit
	always_comb begin
		phase_nxt = phase_r;
		samp_nxt  = samp_r;
		done_nxt  = 1'b0;
		level_nxt = level_r;
		noise_nxt = noise_r;
		if (restart) begin
			phase_nxt = '0;
		end else if (tick) begin
			phase_nxt = (phase_r == PH_LAST) ? '0 : phase_r + 1'b1;
			if (phase_r == PH_MID - 1'b1) begin
				samp_nxt[0] = rxIn; // see (R3)
			end
			if (phase_r == PH_MID) begin
				samp_nxt[1] = rxIn;
			end
			if (phase_r == PH_MID + 1'b1) begin
				// majority of three; any disagreement counts as noise
				level_nxt = (samp_r[0] & samp_r[1]) | (samp_r[0] & rxIn) |
					(samp_r[1] & rxIn); // see (R3)
				noise_nxt = !((samp_r[0] == rxIn) && (samp_r[1] == rxIn));
				done_nxt  = 1'b1; // see (R2)
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			phase_r <= '0;
			samp_r  <= 3'h0;
			done_r  <= 1'b0;
			level_r <= 1'b1;
			noise_r <= 1'b0;
		end else begin
			phase_r <= phase_nxt;
			samp_r  <= samp_nxt;
			done_r  <= done_nxt;
			level_r <= level_nxt;
			noise_r <= noise_nxt;
		end
	end

	assign bitDone  = done_r;
	assign bitLevel = level_r;
	assign bitNoise = noise_r;

endmodule

// ---- hw/urx_receiver.sv ----
// serial receiver with two-entry buffer, error flags and register port
`timescale 1ns/1ps
// Functional notes
// (R1) eight or nine bit words, ninth bit reported
// (R2) sixteen times oversampling, one shift per bit
// (R3) three samples, majority vote per bit
// (R4) word moves to buffer after stop bit
// (R5) data arrives least significant bit first
// (R6) two-word buffer, third word still shifts
// (R7) third word when full: overrun, buffer kept
// (R8) software configures, then enables receiver
// (R9) avail flag; request on transfer or overrun
// (R10) status access then data read clears flags
// (R11) break: framing error, zero word, flags set
// (R12) after break wait for high line
// (R13) idle flag low from start to stop
// (R14) noise flag rises with avail, no request
// (R15) low stop bit sets framing error
// (R16) parity error only when parity enabled
// (R17) error flags travel with their word
// (R18) software reads errors before data word
// (R19) software reads before third word completes
// (R20) port disable flushes buffer, clears flags
// (R21) start, 8 or 9 bits, 1-2 two_stop_sel
// (R22) align to start edge, reject false start
// (R23) tick from baud generator, hold when disabled
module urx_receiver #(
	parameter int FIFO_DEPTH = urx_pkg::FIFO_DEPTH_DEF,
	parameter int OVERSAMPLE = urx_pkg::OVERSAMPLE_DEF
) (
	input  wire logic                       mclk,
	input  wire logic                       reset,
	input  wire logic                       baudTick16,
	input  wire logic                       rxPin,
	input  wire logic [urx_pkg::ADDR_W-1:0] busAddr,
	input  wire logic [urx_pkg::DATA_W-1:0] busWdata,
	input  wire logic                       busWr,
	input  wire logic                       busRd,
	output logic      [urx_pkg::DATA_W-1:0] busRdata_r,
	output logic                            rxIrqReq_r
);
	import urx_pkg::*;

	localparam int PTR_W = $clog2(FIFO_DEPTH);
	localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FIFO_DEPTH);

	if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk
		$error("FIFO_DEPTH must be a power of two of at least 2");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic                        rxMeta_r, rxSync_r;
	logic [7:0]                  ctrl_r, ctrl_nxt;
	urx_state_t                  state_r, state_nxt;
	logic [3:0]                  bitIdx_r, bitIdx_nxt;
	logic [WORD_W-1:0]           shift_r, shift_nxt;
	logic                        frameNoise_r, frameNoise_nxt;
	logic                        frameFerr_r, frameFerr_nxt;
	logic [ENTRY_W-1:0]          fifoMem_r [FIFO_DEPTH];
	logic [PTR_W-1:0]            wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
	logic [CNT_W-1:0]            count_r, count_nxt;
	logic                        overrun_r, overrun_nxt;
	logic                        noise_r, noise_nxt;
	logic                        statusSeen_r, statusSeen_nxt;
	logic [DATA_W-1:0]           busRdata_nxt;
	logic                        rxIrqReq_nxt;

	logic                        bitDone, bitLevel, bitNoise, sampRestart;
	logic                        pushEn, popEn, overrunEv, frameDone, stopOk;
	logic                        statusRead, dataRead, parErr;
	logic [ENTRY_W-1:0]          headEntry, pushEntry;
	logic [WORD_W-1:0]           wordBits;
	logic [3:0]                  lastIdx;
	logic                        portEn, receiver_enable, idleFlag;

	assign portEn   = ctrl_r[CB_PORT_EN];
	assign receiver_enable     = ctrl_r[CB_RX_EN];
	assign idleFlag = (state_r == ST_IDLE) || (state_r == ST_BRKWAIT); // see (R13)
	assign headEntry = fifoMem_r[rdPtr_r];

	// ----------------------------------------------------------------
	// rx pin synchroniser
	// ----------------------------------------------------------------
	// the pin is asynchronous; only the second stage is ever looked at
	always_ff @(posedge mclk) begin
		if (reset) begin
			rxMeta_r <= 1'b1;
			rxSync_r <= 1'b1;
		end else begin
			rxMeta_r <= rxPin;
			rxSync_r <= rxMeta_r;
		end
	end

	urx_bit_sampler #(
		.OVERSAMPLE (OVERSAMPLE)
	) u_sampler (
		.mclk     (mclk),
		.reset    (reset),
		.tick     (baudTick16),
		.restart  (sampRestart),
		.rxIn     (rxSync_r),
		.bitDone  (bitDone),
		.bitLevel (bitLevel),
		.bitNoise (bitNoise)
	);

	// ----------------------------------------------------------------
	// next-state logic: bus, frame machine, buffer, flags
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_nxt       = ctrl_r;
		state_nxt      = state_r;
		bitIdx_nxt     = bitIdx_r;
		shift_nxt      = shift_r;
		frameNoise_nxt = frameNoise_r;
		frameFerr_nxt  = frameFerr_r;
		wrPtr_nxt      = wrPtr_r;
		rdPtr_nxt      = rdPtr_r;
		count_nxt      = count_r;
		overrun_nxt    = overrun_r;
		noise_nxt      = noise_r;
		statusSeen_nxt = statusSeen_r;
		busRdata_nxt   = '0;
		sampRestart    = 1'b0;
		frameDone      = 1'b0;
		stopOk         = 1'b1;
		pushEn         = 1'b0;
		overrunEv      = 1'b0;
		lastIdx = ctrl_r[CB_NINE_SEL] ? LAST_IDX_NINE : LAST_IDX_EIGHT; // see (R1) (R21)
		wordBits = ctrl_r[CB_NINE_SEL] ? shift_r : {1'b0, shift_r[7:0]};
		// odd selection flips the expected sum of ones
		parErr = ctrl_r[CB_PAR_EN] && ((^wordBits) ^ ctrl_r[CB_PAR_ODD]); // see (R16)
		statusRead = busRd && (busAddr == ADDR_STATUS);
		dataRead   = busRd && (busAddr == ADDR_DATA);
		popEn      = dataRead && (count_r != '0);

		// register writes; configuration is software's to order
		if (busWr && (busAddr == ADDR_CTRL)) begin
			ctrl_nxt = busWdata & CTRL_MASK; // see (R8)
		end

		// read data stands only in the cycle after the strobe
		if (busRd) begin
			case (busAddr)
				ADDR_CTRL: busRdata_nxt = ctrl_r & CTRL_MASK;
				ADDR_STATUS: begin
					busRdata_nxt[SB_AVAIL]   = (count_r != '0); // see (R9)
					busRdata_nxt[SB_OVERRUN] = overrun_r;
					busRdata_nxt[SB_NOISE]   = noise_r;
					busRdata_nxt[SB_FRAMING_ERR_FLAG]    = (count_r != '0) && headEntry[EB_FRAMING_ERR_FLAG]; // see (R17)
					busRdata_nxt[SB_PARITY_ERR_FLAG]    = (count_r != '0) && headEntry[EB_PARITY_ERR_FLAG];
					busRdata_nxt[SB_IDLE]    = idleFlag;
					busRdata_nxt[SB_NINTH]   = (count_r != '0) && headEntry[8]; // see (R1)
				end
				ADDR_DATA: busRdata_nxt = (count_r != '0) ? headEntry[7:0] : '0;
				default: busRdata_nxt = '0;
			endcase
		end

		// frame machine; the shifter itself is never on the bus (see (R4))
		case (state_r)
			ST_IDLE: begin
				if (baudTick16 && !rxSync_r) begin
					sampRestart    = 1'b1; // see (R22)
					state_nxt      = ST_START;
					bitIdx_nxt     = 4'h0;
					shift_nxt      = '0;
					frameNoise_nxt = 1'b0;
					frameFerr_nxt  = 1'b0;
				end
			end
			ST_START: begin
				if (bitDone) begin
					// a glitch that is high again by mid-bit is no start
					state_nxt      = bitLevel ? ST_IDLE : ST_DATA; // see (R22)
					frameNoise_nxt = bitNoise;
				end
			end
			ST_DATA: begin
				if (bitDone) begin
					shift_nxt[bitIdx_r] = bitLevel; // see (R5) (R2)
					frameNoise_nxt = frameNoise_r | bitNoise;
					if (bitIdx_r == lastIdx) begin
						state_nxt = ST_STOP1;
					end else begin
						bitIdx_nxt = bitIdx_r + 4'h1;
					end
				end
			end
			ST_STOP1: begin
				if (bitDone) begin
					frameNoise_nxt = frameNoise_r | bitNoise;
					if (ctrl_r[CB_TWO_STOP]) begin
						frameFerr_nxt = !bitLevel; // see (R15)
						state_nxt     = ST_STOP2;
					end else begin
						frameDone = 1'b1;
						stopOk    = bitLevel; // see (R15)
					end
				end
			end
			ST_STOP2: begin
				if (bitDone) begin
					frameNoise_nxt = frameNoise_r | bitNoise;
					frameDone = 1'b1;
					stopOk    = bitLevel && !frameFerr_r; // see (R15)
				end
			end
			ST_BRKWAIT: begin
				// a held-low line is never taken as the next start
				if (rxSync_r) begin
					state_nxt = ST_IDLE; // see (R12)
				end
			end
			default: state_nxt = ST_IDLE;
		endcase

		// a break ends after the configured bit count with a zero word
		if (frameDone) begin
			if ((count_r != CNT_FULL) || popEn) begin
				pushEn = 1'b1; // see (R4) (R11)
			end else begin
				overrunEv = 1'b1; // see (R7)
			end
			state_nxt = (!stopOk && !rxSync_r) ? ST_BRKWAIT : ST_IDLE; // see (R11) (R12)
		end
		pushEntry = {parErr, !stopOk, shift_r}; // see (R17)

		// buffer pointers; the third word sits in the shifter (see (R6))
		if (popEn) begin
			rdPtr_nxt = rdPtr_r + 1'b1;
		end
		if (pushEn) begin
			wrPtr_nxt = wrPtr_r + 1'b1;
		end
		count_nxt = count_r + CNT_W'(pushEn) - CNT_W'(popEn);

		// status access arms the clear, the data read fires it
		if (statusRead) begin
			statusSeen_nxt = 1'b1;
		end
		if (dataRead) begin
			statusSeen_nxt = 1'b0;
			if (statusSeen_r) begin
				overrun_nxt = 1'b0; // see (R10)
				noise_nxt   = 1'b0;
			end
		end
		// sets come last so an event in the clearing cycle survives
		if (overrunEv) begin
			overrun_nxt = 1'b1; // see (R7)
		end
		if (pushEn && frameNoise_nxt) begin
			noise_nxt = 1'b1; // see (R14)
		end
		// noise alone never requests; it rides on the transfer
		rxIrqReq_nxt = ctrl_r[CB_IRQ_EN] && (pushEn || overrunEv); // see (R9) (R14)

		// receiver off: machine parks, buffer kept
		if (!receiver_enable) begin
			state_nxt    = ST_IDLE; // see (R23)
			rxIrqReq_nxt = 1'b0;
			if (pushEn) begin
				wrPtr_nxt = wrPtr_r;
				count_nxt = count_r - CNT_W'(popEn);
			end
			noise_nxt   = (pushEn && frameNoise_nxt) ? noise_r : noise_nxt;
			overrun_nxt = overrunEv ? overrun_r : overrun_nxt;
		end
		// port off: flush buffer, flags and machine, and clear the receiver enable bit
		if (!portEn) begin
			ctrl_nxt[CB_RX_EN] = 1'b0; // see (R20)
			state_nxt      = ST_IDLE;
			wrPtr_nxt      = '0;
			rdPtr_nxt      = '0;
			count_nxt      = '0;
			overrun_nxt    = 1'b0;
			noise_nxt      = 1'b0;
			statusSeen_nxt = 1'b0;
			rxIrqReq_nxt   = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (reset) begin
			ctrl_r       <= CTRL_RESET;
			state_r      <= ST_IDLE;
			bitIdx_r     <= 4'h0;
			shift_r      <= '0;
			frameNoise_r <= 1'b0;
			frameFerr_r  <= 1'b0;
			wrPtr_r      <= '0;
			rdPtr_r      <= '0;
			count_r      <= '0;
			overrun_r    <= 1'b0;
			noise_r      <= 1'b0;
			statusSeen_r <= 1'b0;
			busRdata_r   <= '0;
			rxIrqReq_r   <= 1'b0;
		end else begin
			ctrl_r       <= ctrl_nxt;
			state_r      <= state_nxt;
			bitIdx_r     <= bitIdx_nxt;
			shift_r      <= shift_nxt;
			frameNoise_r <= frameNoise_nxt;
			frameFerr_r  <= frameFerr_nxt;
			wrPtr_r      <= wrPtr_nxt;
			rdPtr_r      <= rdPtr_nxt;
			count_r      <= count_nxt;
			overrun_r    <= overrun_nxt;
			noise_r      <= noise_nxt;
			statusSeen_r <= statusSeen_nxt;
			busRdata_r   <= busRdata_nxt;
			rxIrqReq_r   <= rxIrqReq_nxt;
		end
	end

	// buffer storage; flushing only moves pointers, the stale words are unreachable
	always_ff @(posedge mclk) begin
		if (pushEn && receiver_enable && portEn) begin
			fifoMem_r[wrPtr_r] <= pushEntry; // see (R17)
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence clearPair;
		statusRead ##1 !dataRead ##1 (dataRead && !overrunEv && portEn);
	endsequence

	sequence stopLowSingle;
		state_r == ST_STOP1 && bitDone && !bitLevel && !ctrl_r[CB_TWO_STOP];
	endsequence

	irq_on_transfer_a: assert property (pushEn && receiver_enable && portEn && ctrl_r[CB_IRQ_EN]
		|=> rxIrqReq_r ##1 !rxIrqReq_r) // see (R9)
		else $error("no receive request after a transfer");

	overrun_keeps_buffer_a: assert property (overrunEv && receiver_enable && portEn
		|=> overrun_r && count_r == CNT_FULL && rdPtr_r == $past(rdPtr_r)) // see (R7)
		else $error("overrun lost buffer contents or flag");

	noise_with_avail_a: assert property ($rose(noise_r) |-> count_r != '0 && $past(pushEn)) // see (R14)
		else $error("noise flag rose without a transfer");

	stop_low_framing_err_flag_a: assert property (stopLowSingle and (count_r != CNT_FULL && receiver_enable && portEn)
		|=> fifoMem_r[$past(wrPtr_r)][EB_FRAMING_ERR_FLAG]) // see (R15)
		else $error("low stop bit stored without framing error");

	clear_sequence_a: assert property (clearPair |=> !overrun_r) // see (R10)
		else $error("status then data read left overrun set");

	overrun_sticky_a: assert property (overrun_r && portEn && !(dataRead && statusSeen_r)
		|=> overrun_r) // see (R10)
		else $error("overrun cleared without the read sequence");

	break_wait_a: assert property (state_r == ST_BRKWAIT && !rxSync_r |=> state_r != ST_START) // see (R12)
		else $error("held-low line taken as a start bit");

	start_from_idle_a: assert property ($rose(state_r == ST_START)
		|-> $past(idleFlag) && !idleFlag) // see (R13)
		else $error("idle flag wrong around start detection");

	false_start_a: assert property (state_r == ST_START && bitDone && bitLevel
		|=> state_r == ST_IDLE) // see (R22)
		else $error("false start bit was not rejected");

	port_off_flush_a: assert property (!portEn |=> count_r == '0 && !overrun_r && !noise_r
		&& !ctrl_r[CB_RX_EN] && idleFlag) // see (R20)
		else $error("port disable did not flush the receiver");

	rx_off_idle_a: assert property (!receiver_enable |=> state_r == ST_IDLE && !rxIrqReq_r) // see (R23)
		else $error("receiver ran while disabled");

endmodule

// ---- sim/urx_tx_model.sv ----
// behavioural remote transmitter that drives the serial line
`timescale 1ns/1ps
module urx_tx_model (
	input  wire logic        mclk,
	input  wire logic        baudTick16,
	input  wire logic        go,
	input  wire logic [15:0] bits,
	input  wire logic [4:0]  len,
	input  wire logic [4:0]  glitchAt,
	output logic             txLine,
	output logic             busy
);
	logic [15:0] sh_r;
	logic [4:0]  n_r;
	logic [3:0]  t_r;
	// the line idles high between frames
	initial begin
		txLine = 1'b1;
		busy = 1'b0;
	end
	// bits[0] is the start bit, then lsb first; sixteen ticks a bit
	always @(posedge mclk) begin
		if (go) begin
			sh_r <= bits;
			n_r <= 5'd0;
			t_r <= 4'd0;
			busy <= 1'b1;
			txLine <= bits[0];
		end else if (busy && baudTick16) begin
			t_r <= t_r + 4'd1;
			if (t_r == 4'd15) begin
				if (n_r + 5'd1 == len) begin
					busy <= 1'b0;
					txLine <= 1'b1;
				end else begin
					n_r <= n_r + 5'd1;
					txLine <= sh_r[n_r + 5'd1];
				end
			end else if (n_r == glitchAt) begin
				// one-tick glitch lands on one vote sample for either start alignment
				txLine <= (t_r == 4'd8) ? ~sh_r[n_r] : sh_r[n_r];
			end
		end
	end
endmodule

// ---- sim/tb_uart_receiver_with_error_flags.sv ----
// self-checking bench for the serial receiver with its line model
`timescale 1ns/1ps
module tb_uart_receiver_with_error_flags;
	import urx_pkg::*;
	logic        mclk, reset, baudTick16, rxPin, busWr, busRd, go, busy;
	logic [1:0]  busAddr, tickCnt;
	logic [7:0]  busWdata, busRdata_r, irqCnt, irqExp, cfg, d;
	logic        rxIrqReq_r, ovr, noise;
	logic [15:0] bits, lfsr;
	logic [4:0]  len, glitchAt;
	logic [10:0] q[$];
	int          err_count, check_count, cycles;

	urx_receiver uut (.mclk(mclk), .reset(reset), .baudTick16(baudTick16), .rxPin(rxPin),
		.busAddr(busAddr), .busWdata(busWdata), .busWr(busWr), .busRd(busRd),
		.busRdata_r(busRdata_r), .rxIrqReq_r(rxIrqReq_r));
	urx_tx_model txm (.mclk(mclk), .baudTick16(baudTick16), .go(go), .bits(bits), .len(len),
		.glitchAt(glitchAt), .txLine(rxPin), .busy(busy));

	// ----------------------------------------------------------------
	// clock, tick, monitors
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// tick every fourth cycle keeps the 2-flop sync under one tick
	always @(posedge mclk) begin
		tickCnt <= tickCnt + 2'd1;
		baudTick16 <= (tickCnt == 2'd3);
		if (rxIrqReq_r === 1'b1) irqCnt <= irqCnt + 8'd1;
		cycles++;
		if (cycles == 60000) begin
			err_count++;
			close_out();
		end
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge mclk);
		busWr <= 1'b1;
		busAddr <= a;
		busWdata <= v;
		@(posedge mclk);
		busWr <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge mclk);
		busRd <= 1'b1;
		busAddr <= a;
		@(posedge mclk);
		busRd <= 1'b0;
		#1;
		v = busRdata_r;
	endtask
	// random words for the line come from this register only
	function automatic logic [15:0] lfsr_step(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// format first, receiver enable last
	task automatic setcfg(input logic [7:0] c);
		cfg = c;
		wr(ADDR_CTRL, c & 8'hfd);
		wr(ADDR_CTRL, c);
	endtask
	function automatic logic [7:0] exp_stat();
		logic [10:0] h;
		h = (q.size() != 0) ? q[0] : 11'h0;
		return {1'b0, h[8], 1'b1, h[EB_PARITY_ERR_FLAG], h[EB_FRAMING_ERR_FLAG], noise, ovr, q.size() != 0};
	endfunction
	// status first, then data: error bits of the head, then its word
	task automatic drain();
		logic [7:0] v;
		while (q.size() != 0) begin
			rd(ADDR_STATUS, v);
			chk(v, exp_stat());
			rd(ADDR_DATA, v);
			chk(v, q[0][7:0]);
			void'(q.pop_front());
			ovr = 1'b0;
			noise = 1'b0;
		end
		rd(ADDR_STATUS, v);
		chk(v, exp_stat());
		chk(irqCnt, irqExp);
	endtask
	// kind 0 normal, 1 break, 2 lone low glitch
	task automatic send(input logic [1:0] bad, input logic [1:0] kind, input logic [4:0] gl);
		logic [15:0] b;
		logic [8:0]  wm;
		logic        two, on;
		int          nb, n;
		lfsr = lfsr_step(lfsr);
		two = cfg[CB_TWO_STOP];
		nb = cfg[CB_NINE_SEL] ? 9 : 8;
		wm = (kind == 2'd1) ? 9'h0 : lfsr[8:0];
		if (nb == 8) wm[8] = 1'b0;
		b = 16'hffff;
		for (n = 0; n < nb; n++) b[n + 1] = wm[n];
		b[0] = 1'b0;
		b[nb + 1] = ~bad[0];
		if (two) b[nb + 2] = ~bad[1];
		if (kind == 2'd1) b = 16'h0000;
		if (kind == 2'd2) b = 16'hffff;
		@(posedge mclk);
		bits <= b;
		len <= (kind == 2'd1) ? 5'd16 : (kind == 2'd2) ? 5'd1 : 5'(nb + 2 + int'(two));
		glitchAt <= gl;
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		repeat (300) @(posedge mclk);
		on = cfg[CB_PORT_EN] & cfg[CB_RX_EN];
		if (kind != 2'd2) begin
			rd(ADDR_STATUS, d);
			chk({7'h0, d[SB_IDLE]}, {7'h0, ~on});
		end
		n = 0;
		while (busy !== 1'b0 && n < 2000) begin
			@(posedge mclk);
			n++;
		end
		repeat (40) @(posedge mclk);
		if (on && kind != 2'd2) begin
			if (q.size() == FIFO_DEPTH_DEF) ovr = 1'b1;
			else begin
				q.push_back({cfg[CB_PAR_EN] & ((^wm) ^ cfg[CB_PAR_ODD]),
					(kind == 2'd1) | bad[0] | (two & bad[1]), wm});
				noise = noise | (gl != 5'd31);
			end
			irqExp = irqExp + {7'h0, cfg[CB_IRQ_EN]};
		end
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		reset = 1'b1;
		{busWr, busRd, go, baudTick16, ovr, noise} = 6'h0;
		busAddr = 2'h0;
		busWdata = 8'h00;
		bits = 16'hffff;
		len = 5'd1;
		glitchAt = 5'd31;
		tickCnt = 2'd0;
		{irqCnt, irqExp, cfg} = 24'h0;
		lfsr = 16'd54448;
		{err_count, check_count, cycles} = {32'd0, 32'd0, 32'd0};
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		rd(ADDR_CTRL, d);
		chk(d, CTRL_RESET);
		rd(ADDR_STATUS, d);
		chk(d, 8'h20);
		rd(ADDR_DATA, d);
		chk(d, 8'h00);
		wr(2'h3, 8'hff);
		wr(ADDR_STATUS, 8'hff);
		rd(2'h3, d);
		chk(d, 8'h00);
		rd(ADDR_STATUS, d);
		chk(d, 8'h20);
		setcfg(8'hff);
		rd(ADDR_CTRL, d);
		chk(d, CTRL_MASK);
		$display("test registers done");
		for (int c = 0; c < 16; c++) begin
			setcfg({1'b0, c[1], c[3:0], 2'b11});
			send(2'b00, 2'd0, 5'd31);
			drain();
		end
		$display("test formats done");
		setcfg(8'h63);
		send(2'b10, 2'd0, 5'd31);
		send(2'b01, 2'd0, 5'd31);
		drain();
		setcfg(8'h43);
		send(2'b01, 2'd0, 5'd31);
		drain();
		$display("test framing done");
		send(2'b00, 2'd0, 5'd4);
		drain();
		$display("test noise done");
		repeat (3) send(2'b00, 2'd0, 5'd31);
		drain();
		$display("test overrun done");
		send(2'b00, 2'd1, 5'd31);
		send(2'b00, 2'd0, 5'd31);
		drain();
		$display("test break done");
		send(2'b00, 2'd2, 5'd0);
		drain();
		setcfg(8'h41);
		send(2'b00, 2'd0, 5'd31);
		drain();
		$display("test rejects done");
		setcfg(8'h43);
		send(2'b00, 2'd0, 5'd31);
		send(2'b00, 2'd0, 5'd31);
		wr(ADDR_CTRL, 8'h42);
		rd(ADDR_CTRL, d);
		chk(d, 8'h40);
		q.delete();
		drain();
		setcfg(8'h43);
		send(2'b00, 2'd0, 5'd31);
		drain();
		$display("test disable done");
		close_out();
	end
endmodule
